// >>> verilog/iarc_top.sv
// Auxiliary receive and interface configuration of a bus talker/listener
// Assumes all inputs come from logic on core_clk; strobes last one cycle
`include "iarc_defines.svh"
`timescale 1ns/100ps

module iarc_top
  import iarc_pkg::*;
(
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst,
  // Register port
  input  wire logic       reg_wr,
  input  wire logic [4:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  // EOS character from its register
  input  wire logic [7:0] eos_char,
  // Talker side
  input  wire logic       tacs,
  input  wire logic [7:0] out_byte,
  output logic            out_eoi,
  // Listener side
  input  wire logic       lacs,
  input  wire logic       rx_valid,
  input  wire logic [7:0] rx_byte,
  input  wire logic       rx_end,
  input  wire logic       dir_read,
  output logic            rfd,
  output logic            rdy,
  output logic            di_flag_set,
  output logic            end_flag_set,
  // Status and interrupt
  input  wire logic       srqs,
  input  wire logic       irq_raw,
  output logic            ist,
  output logic            irq_pin
);

  iarc_top_st_t st_q;
  iarc_top_st_t st_d;
  iarc_opt_if   opt ();

  logic       port_hit;
  logic [2:0] code;
  logic [4:0] cmd;
  logic       fh_cmd;
  logic [1:0] mode;
  logic       tx_match;
  logic       rx_match;
  logic       rx_take;
  logic       eob;

  // Auxiliary command decode, shared by finish handshake and poll flag strobes
  function automatic logic aux_cmd_hit(input logic       hit,
                                       input logic [2:0] cc,
                                       input logic [4:0] cm,
                                       input logic [4:0] want);
    return hit && (cc == `IARC_CODE_CMD) && (cm == want);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Port decode
  always_comb begin
    port_hit = reg_wr && ((reg_addr == `IARC_AUX_OFS_A) ||
                          (reg_addr == `IARC_AUX_OFS_B));
    code     = reg_wdata[`IARC_CODE_HI:`IARC_CODE_LO];
    cmd      = reg_wdata[4:0];
    fh_cmd   = aux_cmd_hit(port_hit, code, cmd, `IARC_CMD_FH);
  end

  // Receive mode from the holdoff pair
  assign mode = {st_q.rha[`IARC_RHA_HOLDOFF_ON_END_SELECT], st_q.rha[`IARC_RHA_HOLDOFF_ON_ALL_SELECT]};

  ////////////////////////////////////////////////////////////////////////////
  // EOS comparators
  iarc_eos_cmp #(.W(8)) u_tx_cmp (
    .data_byte (out_byte),
    .eos_char  (eos_char),
    .full_byte (st_q.rha[`IARC_RHA_FULL]),
    .match     (tx_match)
  );

  iarc_eos_cmp #(.W(8)) u_rx_cmp (
    .data_byte (rx_byte),
    .eos_char  (eos_char),
    .full_byte (st_q.rha[`IARC_RHA_FULL]),
    .match     (rx_match)
  );

  // Byte taken only while listening and ready
  always_comb begin
    rx_take = lacs && rx_valid && (st_q.acc == IARC_ACC_RDY);
    eob     = rx_end || (st_q.rha[`IARC_RHA_END_ON_EOS_RECEIVED] && rx_match);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    st_d         = st_q;
    st_d.rdy     = 1'b0;
    st_d.di_set  = 1'b0;
    st_d.end_set = 1'b0;
    // Config loads through the auxiliary mode port
    if (port_hit && (code == `IARC_CODE_RHA)) begin
      st_d.rha = cmd;
    end
    if (port_hit && (code == `IARC_CODE_IOC)) begin
      st_d.ioc = cmd;
    end
    // EOI goes out with a matching talker byte
    st_d.eoi = tacs && st_q.rha[`IARC_RHA_SEND_END_WITH_EOS] && tx_match;
    // END status on EOS received
    if (lacs && rx_valid && st_q.rha[`IARC_RHA_END_ON_EOS_RECEIVED] && rx_match) begin
      st_d.end_set = 1'b1;
    end
    // Acceptor handshake
    unique case (st_q.acc)
      IARC_ACC_RDY: begin
        if (rx_take) begin
          st_d.di_set = (mode != `IARC_MODE_CONT);
          if (mode == `IARC_MODE_HOLDOFF_ON_ALL_SELECT) begin
            st_d.acc = IARC_ACC_HOLD;
          end else if ((mode == `IARC_MODE_HOLDOFF_ON_END_SELECT) && eob) begin
            st_d.acc = IARC_ACC_HOLD;
          end else if ((mode == `IARC_MODE_CONT) && eob) begin
            st_d.acc = IARC_ACC_HOLD;
          end else begin
            st_d.acc = IARC_ACC_WAIT;
          end
        end
      end
      IARC_ACC_WAIT: begin
        if (mode == `IARC_MODE_CONT) begin
          st_d.acc = IARC_ACC_RDY;
          st_d.rdy = 1'b1;
        end else if ((mode != `IARC_MODE_HOLDOFF_ON_ALL_SELECT) && dir_read) begin
          st_d.acc = IARC_ACC_RDY;
          st_d.rdy = 1'b1;
        end
      end
      IARC_ACC_HOLD: begin
        if (fh_cmd) begin
          st_d.acc = IARC_ACC_RDY;
          st_d.rdy = 1'b1;
        end
      end
      default: begin
        st_d.acc = IARC_ACC_RDY;
      end
    endcase
  end

  // State register
  always_ff @(posedge core_clk) begin
    if (rst) begin
      st_q.rha     <= `IARC_RHA_RESET;
      st_q.ioc     <= `IARC_IOC_RESET;
      st_q.acc     <= IARC_ACC_RDY;
      st_q.rdy     <= 1'b0;
      st_q.di_set  <= 1'b0;
      st_q.end_set <= 1'b0;
      st_q.eoi     <= 1'b0;
    end else begin
      st_q <= st_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status and interrupt outputs
  always_comb begin
    opt.ist_source_select = st_q.ioc[`IARC_IOC_ISS];
    opt.irq_polarity_flip = st_q.ioc[`IARC_IOC_INV];
    opt.pp_set  = aux_cmd_hit(port_hit, code, cmd, `IARC_CMD_PP_SET);
    opt.pp_clr  = aux_cmd_hit(port_hit, code, cmd, `IARC_CMD_PP_CLR);
    opt.srqs    = srqs;
    opt.irq_raw = irq_raw;
  end

  iarc_ist_irq u_ist_irq (
    .core_clk (core_clk),
    .rst      (rst),
    .opt      (opt.outs)
  );

  // Outputs
  assign ist          = opt.ist;
  assign irq_pin      = opt.irq_pin;
  assign out_eoi      = st_q.eoi;
  assign rfd          = (st_q.acc == IARC_ACC_RDY);
  assign rdy          = st_q.rdy;
  assign di_flag_set  = st_q.di_set;
  assign end_flag_set = st_q.end_set;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  rha_load_a: assert property (@(posedge core_clk) disable iff (rst)
    (port_hit && (code == `IARC_CODE_RHA)) |=> (st_q.rha == $past(reg_wdata[4:0])))
    else $error("receive handshake config not loaded");
  ioc_load_a: assert property (@(posedge core_clk) disable iff (rst)
    (reg_wr && (reg_addr == `IARC_AUX_OFS_B) && (code == `IARC_CODE_IOC))
      |=> (st_q.ioc == $past(reg_wdata[4:0])))
    else $error("interface options config not loaded via port B");
  port_alias_a: assert property (@(posedge core_clk) disable iff (rst)
    (reg_wr && (reg_addr != `IARC_AUX_OFS_A) && (reg_addr != `IARC_AUX_OFS_B))
      |=> ((st_q.rha == $past(st_q.rha)) && (st_q.ioc == $past(st_q.ioc))))
    else $error("config changed by write to another location");
  eos_seven_a: assert property (@(posedge core_clk) disable iff (rst)
    (tacs && st_q.rha[`IARC_RHA_SEND_END_WITH_EOS] && !st_q.rha[`IARC_RHA_FULL] &&
     (out_byte[6:0] == eos_char[6:0])) |=> out_eoi)
    else $error("seven-bit EOS match missed");
  eoi_send_a: assert property (@(posedge core_clk) disable iff (rst)
    out_eoi |-> $past(tacs && st_q.rha[`IARC_RHA_SEND_END_WITH_EOS] && tx_match))
    else $error("EOI sent without matching talker byte");
  end_on_eos_a: assert property (@(posedge core_clk) disable iff (rst)
    (lacs && rx_valid && st_q.rha[`IARC_RHA_END_ON_EOS_RECEIVED] && rx_match) |=> end_flag_set)
    else $error("END flag not set on EOS");
  normal_read_a: assert property (@(posedge core_clk) disable iff (rst)
    ((st_q.acc == IARC_ACC_WAIT) && (mode == `IARC_MODE_NORMAL) && dir_read)
      |=> (rfd && rdy))
    else $error("normal read did not restart handshake");
  hold_all_a: assert property (@(posedge core_clk) disable iff (rst)
    (rx_take && (mode == `IARC_MODE_HOLDOFF_ON_ALL_SELECT)) ##1 (!fh_cmd) [*2] |-> !rfd)
    else $error("holdoff on all released without finish");
  hold_end_a: assert property (@(posedge core_clk) disable iff (rst)
    (rx_take && (mode == `IARC_MODE_HOLDOFF_ON_END_SELECT) && eob) |=> (st_q.acc == IARC_ACC_HOLD))
    else $error("holdoff on END missed end of block");
  cont_auto_a: assert property (@(posedge core_clk) disable iff (rst)
    (rx_take && (mode == `IARC_MODE_CONT) && !eob) |=> !rfd ##1 (rfd && rdy))
    else $error("continuous mode did not auto-ready");
  cont_no_di_a: assert property (@(posedge core_clk) disable iff (rst)
    (rx_take && (mode == `IARC_MODE_CONT)) |=> !di_flag_set)
    else $error("data-in set in continuous mode");
  mode_normal_a: assert property (@(posedge core_clk) disable iff (rst)
    (rx_take && (mode == `IARC_MODE_NORMAL)) |=> (di_flag_set && (st_q.acc == IARC_ACC_WAIT)))
    else $error("normal mode did not wait for read");
  reset_cfg_a: assert property (@(posedge core_clk)
    rst |=> ((st_q.rha == `IARC_RHA_RESET) && (st_q.ioc == `IARC_IOC_RESET)))
    else $error("configs not cleared by reset");
  reset_outs_a: assert property (@(posedge core_clk)
    rst |=> (rfd && !rdy && !di_flag_set && !end_flag_set && !out_eoi))
    else $error("outputs not idle after reset");

  // Port A location loads the options config as well
  ioc_alias_a: assert property (@(posedge core_clk) disable iff (rst)
    (reg_wr && (reg_addr == `IARC_AUX_OFS_A) && (code == `IARC_CODE_IOC))
      |=> (st_q.ioc == $past(reg_wdata[4:0])))
    else $error("interface options config not loaded via port A");

  // Full-byte compare refuses a top-bit mismatch
  eos_full_a: assert property (@(posedge core_clk) disable iff (rst)
    (st_q.rha[`IARC_RHA_FULL] && (out_byte[7] != eos_char[7])) |=> !out_eoi)
    else $error("full-byte EOS matched on differing top bit");

  // Holdoff stays until finish handshake, then restarts
  hold_keep_a: assert property (@(posedge core_clk) disable iff (rst)
    ((st_q.acc == IARC_ACC_HOLD) && !fh_cmd) |=> !rfd)
    else $error("holdoff released without finish");
  fh_release_a: assert property (@(posedge core_clk) disable iff (rst)
    ((st_q.acc == IARC_ACC_HOLD) && fh_cmd) |=> (rfd && rdy))
    else $error("finish handshake did not release holdoff");

  // Holdoff on END passes ordinary bytes to a normal wait
  holdoff_on_end_select_pass_a: assert property (@(posedge core_clk) disable iff (rst)
    (rx_take && (mode == `IARC_MODE_HOLDOFF_ON_END_SELECT) && !eob) |=> (st_q.acc == IARC_ACC_WAIT))
    else $error("holdoff on END held an ordinary byte");

  // Continuous mode holds off at end of block
  cont_end_a: assert property (@(posedge core_clk) disable iff (rst)
    (rx_take && (mode == `IARC_MODE_CONT) && eob) |=> (st_q.acc == IARC_ACC_HOLD))
    else $error("continuous mode missed end of block");

endmodule

// >>> verilog/iarc_defines.svh
// Offsets, field positions, codes and reset values of the auxiliary config block
// Assumes inclusion by bare name from any design file that needs them
`ifndef IARC_DEFINES_SVH
`define IARC_DEFINES_SVH

// Auxiliary mode port locations, port A and port B
`define IARC_AUX_OFS_A      5'h0b
`define IARC_AUX_OFS_B      5'h1b

// Control code field, bits 7 to 5 of a port write
`define IARC_CODE_HI        7
`define IARC_CODE_LO        5
`define IARC_CODE_CMD       3'h0
`define IARC_CODE_RHA       3'h4
`define IARC_CODE_IOC       3'h5

// Auxiliary command codes carried in the low five bits with code 000
`define IARC_CMD_FH         5'h03
`define IARC_CMD_PP_SET     5'h0d
`define IARC_CMD_PP_CLR     5'h05

// Receive handshake config fields
`define IARC_RHA_FULL       4
`define IARC_RHA_SEND_END_WITH_EOS       3
`define IARC_RHA_END_ON_EOS_RECEIVED       2
`define IARC_RHA_HOLDOFF_ON_END_SELECT       1
`define IARC_RHA_HOLDOFF_ON_ALL_SELECT       0

// Interface options config fields
`define IARC_IOC_ISS        4
`define IARC_IOC_INV        3

// Receive modes, {holdoff on END, holdoff on all}
`define IARC_MODE_NORMAL    2'h0
`define IARC_MODE_HOLDOFF_ON_ALL_SELECT      2'h1
`define IARC_MODE_HOLDOFF_ON_END_SELECT      2'h2
`define IARC_MODE_CONT      2'h3

// Reset values
`define IARC_RHA_RESET      5'h00
`define IARC_IOC_RESET      5'h00

`endif

// >>> verilog/iarc_pkg.sv
// Types shared by the auxiliary config block
// Assumes the defines header is compiled alongside
package iarc_pkg;

  // Acceptor handshake states
  typedef enum logic [1:0] {
    IARC_ACC_RDY,
    IARC_ACC_WAIT,
    IARC_ACC_HOLD
  } iarc_acc_t;

  // Top-level state
  typedef struct packed {
    logic [4:0] rha;
    logic [4:0] ioc;
    iarc_acc_t  acc;
    logic       rdy;
    logic       di_set;
    logic       end_set;
    logic       eoi;
  } iarc_top_st_t;

  // Status-output state
  typedef struct packed {
    logic pp_flag;
    logic ist;
    logic irq;
  } iarc_opt_st_t;

endpackage

// >>> verilog/iarc_opt_if.sv
// Carrier between the top and the ist / interrupt output module
// Assumes one clock domain shared by both ends
`timescale 1ns/100ps

interface iarc_opt_if;
  logic ist_source_select;
  logic irq_polarity_flip;
  logic pp_set;
  logic pp_clr;
  logic srqs;
  logic irq_raw;
  logic ist;
  logic irq_pin;

  modport ctrl (output ist_source_select, irq_polarity_flip, pp_set, pp_clr, srqs, irq_raw,
                input ist, irq_pin);
  modport outs (input ist_source_select, irq_polarity_flip, pp_set, pp_clr, srqs, irq_raw,
                output ist, irq_pin);
endinterface

// >>> verilog/iarc_eos_cmp.sv
// EOS character comparator, seven or eight bits wide
// Assumes inputs from logic on the same clock
`timescale 1ns/100ps

module iarc_eos_cmp #(
  parameter int W = 8
) (
  // Operands
  input  wire logic [W-1:0] data_byte,
  input  wire logic [W-1:0] eos_char,
  // Width select
  input  wire logic         full_byte,
  // Result
  output logic              match
);

  // Top bit ignored unless the full byte is selected
  always_comb begin
    match = (data_byte[W-2:0] == eos_char[W-2:0]) &&
            (!full_byte || (data_byte[W-1] == eos_char[W-1]));
  end

endmodule

// >>> verilog/iarc_ist_irq.sv
// Individual status source, parallel poll flag and interrupt polarity
// Assumes set and clear pulses last one cycle
`timescale 1ns/100ps

module iarc_ist_irq
  import iarc_pkg::*;
(
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic rst,
  // Control side
  iarc_opt_if.outs  opt
);

  iarc_opt_st_t st_q;
  iarc_opt_st_t st_d;

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    st_d = st_q;
    // Flag moves only on its two commands
    if (opt.pp_set) begin
      st_d.pp_flag = 1'b1;
    end else if (opt.pp_clr) begin
      st_d.pp_flag = 1'b0;
    end
    st_d.ist = opt.ist_source_select ? opt.srqs : st_q.pp_flag;
    st_d.irq = opt.irq_polarity_flip ? !opt.irq_raw : opt.irq_raw;
  end

  // State register
  always_ff @(posedge core_clk) begin
    if (rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign opt.ist     = st_q.ist;
  assign opt.irq_pin = st_q.irq;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  pp_flag_cmd_a: assert property (@(posedge core_clk) disable iff (rst)
    ($past(st_q.pp_flag) != st_q.pp_flag) |-> ($past(opt.pp_set) || $past(opt.pp_clr)))
    else $error("parallel poll flag moved without a command");
  ist_select_a: assert property (@(posedge core_clk) disable iff (rst)
    opt.ist_source_select |=> (opt.ist == $past(opt.srqs)))
    else $error("ist does not follow service request state");
  ist_flag_a: assert property (@(posedge core_clk) disable iff (rst)
    !opt.ist_source_select |=> (opt.ist == $past(st_q.pp_flag)))
    else $error("ist does not follow parallel poll flag");
  irq_polarity_a: assert property (@(posedge core_clk) disable iff (rst)
    1'b1 |=> (opt.irq_pin == ($past(opt.irq_raw) ^ $past(opt.irq_polarity_flip))))
    else $error("interrupt pin polarity wrong");

endmodule

// >>> tb/iarc_src_model.sv
// Bus source model that offers received bytes to the listener side
// Assumes one clock; a byte is offered only while rfd is high
`timescale 1ns/100ps

module iarc_src_model (
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst,
  // Bench request and answer delay
  input  wire logic       go,
  input  wire logic [1:0] lag,
  input  wire logic [7:0] byte_in,
  input  wire logic       end_in,
  // Acceptor side
  input  wire logic       rfd,
  output logic            rx_valid,
  output logic [7:0]      rx_byte,
  output logic            rx_end
);
  logic       pend_q;
  logic [1:0] cnt_q;

  // One byte per request, after a short lag, never while held off
  always_ff @(posedge core_clk) begin
    if (rst) begin
      pend_q   <= 1'b0;
      cnt_q    <= 2'h0;
      rx_valid <= 1'b0;
      rx_byte  <= 8'h00;
      rx_end   <= 1'b0;
    end else if (pend_q && cnt_q == 2'h0 && rfd && !rx_valid) begin
      pend_q   <= 1'b0;
      rx_valid <= 1'b1;
      rx_byte  <= byte_in;
      rx_end   <= end_in;
    end else begin
      if (go) begin
        pend_q <= 1'b1;
        cnt_q  <= lag;
      end else if (cnt_q != 2'h0) cnt_q <= cnt_q - 2'h1;
      rx_valid <= 1'b0;
      rx_byte  <= ~rx_byte;  // Released lines toggle the last byte every cycle
      rx_end   <= ~rx_end;
    end
  end
endmodule

// >>> tb/tb.sv
// Self-checking bench of the auxiliary receive and options config block
// Assumes the source model drives the listener byte inputs
`timescale 1ns/100ps

module tb;
  logic       core_clk, rst, reg_wr, tacs, out_eoi, lacs, rx_valid, rx_end, dir_read;
  logic       rfd, rdy, di_flag_set, end_flag_set, srqs, irq_raw, ist, irq_pin, go, s_end;
  logic [4:0] reg_addr;
  logic [7:0] reg_wdata, eos_char, out_byte, rx_byte, s_byte, eos, b;
  logic [1:0] lag;
  logic       full, xe, t, r;
  int         miscompares, n_tests, m, i;

  iarc_top uut (.core_clk(core_clk), .rst(rst), .reg_wr(reg_wr), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .eos_char(eos_char), .tacs(tacs), .out_byte(out_byte),
    .out_eoi(out_eoi), .lacs(lacs), .rx_valid(rx_valid), .rx_byte(rx_byte),
    .rx_end(rx_end), .dir_read(dir_read), .rfd(rfd), .rdy(rdy),
    .di_flag_set(di_flag_set), .end_flag_set(end_flag_set), .srqs(srqs),
    .irq_raw(irq_raw), .ist(ist), .irq_pin(irq_pin));

  iarc_src_model src (.core_clk(core_clk), .rst(rst), .go(go), .lag(lag), .byte_in(s_byte),
    .end_in(s_end), .rfd(rfd), .rx_valid(rx_valid), .rx_byte(rx_byte), .rx_end(rx_end));

  ////////////////////////////////////////////////////////////////////////////////
  // Clock
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Helpers
  function automatic logic eos_hit(input logic [7:0] d, input logic [7:0] e, input logic f);
    return f ? (d == e) : (d[6:0] == e[6:0]);
  endfunction

  task automatic test_done();
    $display("checks %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] s);
    n_tests++;
    if (e !== s) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask

  // Write one aux mode port byte
  task automatic wr(input logic [4:0] a, input logic [2:0] c, input logic [4:0] p);
    @(posedge core_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= {c, p};
    @(posedge core_clk);
    reg_wr <= 1'b0;
    #1;
  endtask

  task automatic rd();
    @(posedge core_clk);
    dir_read <= 1'b1;
    @(posedge core_clk);
    dir_read <= 1'b0;
    #1;
  endtask

  // Receive one byte and check the flag pulses and the holdoff
  task automatic send(input logic [7:0] d, input logic e, input logic x_di, input logic x_end);
    @(posedge core_clk);
    s_byte <= d;
    s_end  <= e;
    lag    <= 2'($urandom);
    go     <= 1'b1;
    @(posedge core_clk);
    go <= 1'b0;
    #1;
    for (i = 0; i < 20 && rx_valid !== 1'b1; i++) begin
      @(posedge core_clk);
      #1;
    end
    if (i == 20) begin
      miscompares++;
      test_done();
    end
    @(posedge core_clk);
    #1;
    chk("di_flag_set", x_di, di_flag_set);
    chk("end_flag_set", x_end, end_flag_set);
    chk("rfd after byte", 1'b0, rfd);
  endtask

  // Release as the mode demands, then expect rfd and rdy
  task automatic hand_back(input logic [1:0] md, input logic eob);
    if (md == 2'h3 && !eob) begin
      @(posedge core_clk);
      #1;
    end else begin
      rd();
      if (md != 2'h0 && (md == 2'h1 || eob)) begin
        repeat (3) @(posedge core_clk);
        #1;
        chk("rfd held", 1'b0, rfd);
        wr(5'h0b, 3'h0, 5'h03);
      end
    end
    chk("rfd", 1'b1, rfd);
    chk("rdy", 1'b1, rdy);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    rst = 1'b1; reg_wr = 1'b0; reg_addr = 5'h00; reg_wdata = 8'h00; eos_char = 8'h0a;
    tacs = 1'b0; out_byte = 8'h00; lacs = 1'b1; dir_read = 1'b0; srqs = 1'b1;
    irq_raw = 1'b1; go = 1'b0; lag = 2'h0; s_byte = 8'h00; s_end = 1'b0;
    miscompares = 0;
    n_tests = 0;
    void'($urandom(32'ha57d6850));
    repeat (16) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    #1;
    chk("rfd", 1'b1, rfd);
    chk("ist", 1'b0, ist);
    chk("irq_pin", 1'b1, irq_pin);
    // Unmapped location must not load the holdoff mode
    wr(5'h0c, 3'h4, 5'h01);
    send(8'h41, 1'b0, 1'b1, 1'b0);
    hand_back(2'h0, 1'b0);
    // All four receive modes, through both port locations
    for (m = 0; m < 4; m++) begin
      full = 1'($urandom);
      eos  = 8'($urandom);
      eos_char <= eos;
      wr(m[0] ? 5'h1b : 5'h0b, 3'h4, {full, 1'b0, 1'b1, m[1:0]});
      send(eos ^ 8'h01, 1'b0, m != 3, 1'b0);
      hand_back(m[1:0], 1'b0);
      send(eos ^ 8'h80, 1'b0, m != 3, !full);
      hand_back(m[1:0], !full);
      send(eos ^ 8'h02, 1'b1, m != 3, 1'b0);
      hand_back(m[1:0], 1'b1);
    end
    // Talker EOI with matching bytes
    for (m = 0; m < 16; m++) begin
      full = m[0];
      xe   = m[2] | m[3];
      t    = 1'($urandom);
      b    = eos ^ (m[1] ? 8'h80 : 8'h00) ^ (m[3] ? 8'($urandom) : 8'h00);
      wr(5'h1b, 3'h4, {full, xe, 3'h0});
      @(posedge core_clk);
      tacs     <= t;
      out_byte <= b;
      repeat (2) @(posedge core_clk);
      #1;
      chk("out_eoi", t & xe & eos_hit(b, eos, full), out_eoi);
    end
    // Parallel poll flag as ist source
    wr(5'h0b, 3'h5, 5'h00);
    wr(5'h0b, 3'h0, 5'h0d);
    repeat (2) @(posedge core_clk);
    #1;
    chk("ist pp set", 1'b1, ist);
    wr(5'h0b, 3'h0, 5'h03);
    wr(5'h1b, 3'h4, 5'h00);
    repeat (2) @(posedge core_clk);
    #1;
    chk("ist pp kept", 1'b1, ist);
    wr(5'h1b, 3'h0, 5'h05);
    repeat (2) @(posedge core_clk);
    #1;
    chk("ist pp clr", 1'b0, ist);
    // Service request state as ist source
    wr(5'h0b, 3'h5, 5'h10);
    for (m = 0; m < 8; m++) begin
      r = 1'($urandom);
      @(posedge core_clk);
      srqs <= r;
      repeat (2) @(posedge core_clk);
      #1;
      chk("ist srqs", r, ist);
    end
    // Interrupt polarity both ways, left clear at the end
    for (m = 0; m < 16; m++) begin
      if (m % 8 == 0) wr(5'h0b, 3'h5, {1'b0, m[3], 3'h0});
      r = 1'($urandom);
      @(posedge core_clk);
      irq_raw <= r;
      repeat (2) @(posedge core_clk);
      #1;
      chk("irq_pin", r ^ m[3], irq_pin);
    end
    wr(5'h0b, 3'h5, 5'h00);
    test_done();
  end
endmodule
